// [hw/sgr_regs.svh]
// command fields, reset values and timing counts of the serial pin block
`ifndef SGR_REGS_SVH
`define SGR_REGS_SVH

// ----------------------------------------------------------------------
// command byte
// ----------------------------------------------------------------------
`define SGR_CMD_BITS       8
`define SGR_RST_SEL_FIELD  7:3
`define SGR_RST_SEL_VAL    5'h01
`define SGR_RST_FULL_BIT   2
`define SGR_RST_SLOW_BIT   1
`define SGR_RST_BIAS_BIT   0
`define SGR_PIN_SEL_FIELD  7:2
`define SGR_PIN_SEL_VAL    6'h00
`define SGR_PIN_OP_FIELD   1:0
`define SGR_PIN_OP_CFG     2'h3
`define SGR_PIN_OP_WR      2'h2
`define SGR_PIN_OP_RD      2'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SGR_CFG_RESET      1'b0
`define SGR_WR_RESET       1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SGR_CLK_PERIOD_NS  8
`define SGR_SLOW_DELAY_NS  15
`define SGR_SLOW_CYCLES \
  ((`SGR_SLOW_DELAY_NS + `SGR_CLK_PERIOD_NS - 1) / `SGR_CLK_PERIOD_NS)
`define SGR_WAKE_MODE_BIT  0

`endif

// [hw/sgr_pkg.sv]
// types shared by the serial pin block
package sgr_pkg;

  // ----------------------------------------------------------------------
  // command parser states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    st_cmd,
    st_cfg,
    st_wr,
    st_rd,
    st_hold
  } sgr_state_e;

  // ----------------------------------------------------------------------
  // controls handed to the converter side
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic full_reset;
    logic fifo_clear;
    logic slow_out;
    logic force_bias_on;
    logic wake_skip;
  } sgr_ctl_s;

endpackage

// [hw/sgr_edge_det.sv]
// rise and fall detector for link inputs sampled on mclk
module sgr_edge_det #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // levels and their edges
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_q <= level;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule

// [hw/sgr_pin_bank.sv]
// pin drivers: direction and output value per general-purpose pin
module sgr_pin_bank #(
  parameter int N = 12
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // committed registers
  input  wire logic [N-1:0] cfg,
  input  wire logic [N-1:0] wr,
  // pins
  output logic      [N-1:0] pin_o,
  output logic      [N-1:0] pin_oe
);

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // one driver per pin
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_pin
    always_ff @(posedge mclk) begin
      if (reset) begin
        pin_o[i]  <= 1'b0;
        pin_oe[i] <= 1'b0;
      end else begin
        pin_o[i]  <= cfg[i] & wr[i];
        pin_oe[i] <= cfg[i] | ~wr[i];
      end
    end
  end

  a_pin_pulldown: assert property (
    (!cfg[0] && !wr[0]) |=> (pin_oe[0] && !pin_o[0]))
    else $error("pulldown pin not driven low");

  a_pin_input: assert property (
    (!cfg[0] && wr[0]) |=> !pin_oe[0])
    else $error("input pin is driven");

  a_pin_output: assert property (
    cfg[0] |=> (pin_oe[0] && pin_o[0] == $past(wr[0])))
    else $error("output pin does not follow write bit");

endmodule

// [hw/sgr_top.sv]
// serial command decoder for reset control and general-purpose pins
module sgr_top
  import sgr_pkg::*;
#(
  parameter int NUM_PINS  = 12,
  parameter int DATA_BITS = (NUM_PINS == 4) ? 8 : 16
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // serial link
  input  wire logic                cs_n,
  input  wire logic                sclk,
  input  wire logic                sdi,
  output logic                     sdo,
  // converter side
  input  wire logic [1:0]          clock_mode,
  output sgr_ctl_s                 ctl_q,
  // general-purpose pins
  input  wire logic [NUM_PINS-1:0] pin_i,
  output logic      [NUM_PINS-1:0] pin_o,
  output logic      [NUM_PINS-1:0] pin_oe
);

`include "sgr_regs.svh"

  localparam int CNT_W      = $clog2(DATA_BITS);
  localparam int SLOW_W     = `SGR_SLOW_CYCLES;
  localparam int SLOW_DEPTH = SLOW_W + 1;
  localparam logic [CNT_W-1:0] CMD_LAST  = CNT_W'(`SGR_CMD_BITS - 1);
  localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DATA_BITS - 1);

  // ----------------------------------------------------------------------
  // command decoding
  // ----------------------------------------------------------------------
  function automatic logic is_rst_cmd(input logic [7:0] b);
    return b[`SGR_RST_SEL_FIELD] == `SGR_RST_SEL_VAL;
  endfunction

  function automatic logic is_pin_cmd(input logic [7:0] b,
                                      input logic [1:0] op);
    return b[`SGR_PIN_SEL_FIELD] == `SGR_PIN_SEL_VAL &&
           b[`SGR_PIN_OP_FIELD] == op;
  endfunction

  // ----------------------------------------------------------------------
  // link edges
  // ----------------------------------------------------------------------
  logic [1:0]           rise;
  logic [1:0]           fall;
  logic                 sck_rise;
  logic                 sck_fall;
  logic                 cs_rise;
  sgr_state_e           state_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [DATA_BITS-1:0] sh_q;
  logic [DATA_BITS-1:0] rd_q;
  logic [7:0]           cmd_byte;
  logic [DATA_BITS-1:0] data_word;
  logic                 cmd_done;
  logic                 data_done;
  logic                 rst_cmd;
  logic                 rst_full;
  logic [NUM_PINS-1:0]  pend_q;
  logic                 pend_cfg_q;
  logic                 pend_wr_q;
  logic [NUM_PINS-1:0]  cfg_q;
  logic [NUM_PINS-1:0]  wr_q;
  logic                 sdo_raw_q;
  logic [SLOW_W-1:0]    dly_q;

  sgr_edge_det #(
    .W (2)
  ) u_edge (
    .mclk  (mclk),
    .reset (reset),
    .level ({cs_n, sclk}),
    .rise  (rise),
    .fall  (fall)
  );

  assign sck_rise  = rise[0] & ~cs_n;
  assign sck_fall  = fall[0] & ~cs_n;
  assign cs_rise   = rise[1];
  assign cmd_byte  = {sh_q[6:0], sdi};
  assign data_word = {sh_q[DATA_BITS-2:0], sdi};
  assign cmd_done  = sck_rise && state_q == st_cmd && cnt_q == CMD_LAST;
  assign data_done = sck_rise && cnt_q == DATA_LAST &&
                     (state_q == st_cfg || state_q == st_wr);
  assign rst_cmd   = cmd_done && is_rst_cmd(cmd_byte);
  assign rst_full  = rst_cmd && cmd_byte[`SGR_RST_FULL_BIT];

  // ----------------------------------------------------------------------
  // bit shifter and command parser
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || cs_n) begin
      state_q <= st_cmd;
      cnt_q   <= '0;
    end else if (sck_rise) begin
      cnt_q <= cnt_q + CNT_W'(1);
      unique case (state_q)
        st_cmd: begin
          if (cnt_q == CMD_LAST) begin
            cnt_q <= '0;
            if (is_pin_cmd(cmd_byte, `SGR_PIN_OP_CFG)) begin
              state_q <= st_cfg;
            end else if (is_pin_cmd(cmd_byte, `SGR_PIN_OP_WR)) begin
              state_q <= st_wr;
            end else if (is_pin_cmd(cmd_byte, `SGR_PIN_OP_RD)) begin
              state_q <= st_rd;
            end else if (!is_rst_cmd(cmd_byte)) begin
              state_q <= st_hold;
            end
          end
        end
        st_cfg, st_wr, st_rd: begin
          if (cnt_q == DATA_LAST) begin
            cnt_q   <= '0;
            state_q <= st_cmd;
          end
        end
        st_hold: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sh_q <= '0;
    end else if (sck_rise) begin
      sh_q <= data_word;
    end
  end

  // ----------------------------------------------------------------------
  // reset control register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_q <= '0;
    end else begin
      ctl_q.full_reset <= 1'b0;
      ctl_q.fifo_clear <= 1'b0;
      ctl_q.wake_skip  <= ctl_q.force_bias_on &&
                          clock_mode[`SGR_WAKE_MODE_BIT];
      if (rst_cmd) begin
        ctl_q.fifo_clear <= 1'b1;
        if (cmd_byte[`SGR_RST_FULL_BIT]) begin
          ctl_q.full_reset    <= 1'b1;
          ctl_q.slow_out      <= 1'b0;
          ctl_q.force_bias_on <= 1'b0;
        end else begin
          ctl_q.slow_out      <= cmd_byte[`SGR_RST_SLOW_BIT];
          ctl_q.force_bias_on <= cmd_byte[`SGR_RST_BIAS_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin registers, committed at chip select rise
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || cs_rise) begin
      pend_q     <= '0;
      pend_cfg_q <= 1'b0;
      pend_wr_q  <= 1'b0;
    end else if (data_done) begin
      pend_q     <= data_word[DATA_BITS-1 -: NUM_PINS];
      pend_cfg_q <= state_q == st_cfg;
      pend_wr_q  <= state_q == st_wr;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || rst_full) begin
      cfg_q <= {NUM_PINS{`SGR_CFG_RESET}};
      wr_q  <= {NUM_PINS{`SGR_WR_RESET}};
    end else if (cs_rise) begin
      if (pend_cfg_q) begin
        cfg_q <= pend_q;
      end
      if (pend_wr_q) begin
        wr_q <= pend_q;
      end
    end
  end

  sgr_pin_bank #(
    .N (NUM_PINS)
  ) u_pins (
    .mclk   (mclk),
    .reset  (reset),
    .cfg    (cfg_q),
    .wr     (wr_q),
    .pin_o  (pin_o),
    .pin_oe (pin_oe)
  );

  // ----------------------------------------------------------------------
  // serial output with optional slow path
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_q <= '0;
    end else if (rst_cmd == 1'b0 && cmd_done &&
                 is_pin_cmd(cmd_byte, `SGR_PIN_OP_RD)) begin
      rd_q <= DATA_BITS'(pin_i);
    end else if (sck_fall && state_q == st_rd) begin
      rd_q <= {rd_q[DATA_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || state_q != st_rd) begin
      sdo_raw_q <= 1'b0;
    end else if (sck_fall) begin
      sdo_raw_q <= rd_q[DATA_BITS-1];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dly_q <= '0;
      sdo   <= 1'b0;
    end else begin
      dly_q <= SLOW_W'({dly_q, sdo_raw_q});
      sdo   <= ctl_q.slow_out ? dly_q[SLOW_W-1] : sdo_raw_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_rst_fifo_only;
    rst_cmd && !cmd_byte[`SGR_RST_FULL_BIT];
  endsequence

  sequence s_rd_cmd;
    cmd_done && is_pin_cmd(cmd_byte, `SGR_PIN_OP_RD);
  endsequence

  a_rst_decode: assert property (
    cmd_done && cmd_byte[`SGR_RST_SEL_FIELD] == `SGR_RST_SEL_VAL
    |=> ctl_q.fifo_clear)
    else $error("reset command not decoded");

  a_full_reset: assert property (
    rst_full |=> (ctl_q.full_reset && !ctl_q.slow_out && cfg_q == '0))
    else $error("full reset did not restore defaults");

  a_fifo_only: assert property (
    s_rst_fifo_only |=> (ctl_q.fifo_clear && !ctl_q.full_reset))
    else $error("fifo-only reset misbehaved");

  a_slow_path: assert property (
    $past(ctl_q.slow_out) |-> sdo == $past(sdo_raw_q, SLOW_DEPTH))
    else $error("slow output delay wrong");

  a_fast_path: assert property (
    !$past(ctl_q.slow_out) |-> sdo == $past(sdo_raw_q))
    else $error("normal output delay wrong");

  a_slow_clear: assert property (
    s_rst_fifo_only ##0 cmd_byte[`SGR_RST_SLOW_BIT]
    |=> (ctl_q.fifo_clear && ctl_q.slow_out))
    else $error("slow write did not clear fifo");

  a_bias_clear: assert property (
    s_rst_fifo_only ##0 cmd_byte[`SGR_RST_BIAS_BIT]
    |=> (ctl_q.fifo_clear && ctl_q.force_bias_on) [*1] ##1
        (ctl_q.force_bias_on || $past(rst_cmd)))
    else $error("force-bias write misbehaved");

  a_wake_skip: assert property (
    ctl_q.wake_skip ==
    $past(ctl_q.force_bias_on && clock_mode[`SGR_WAKE_MODE_BIT]))
    else $error("wake-up skip does not follow force-bias");

  a_pin_select: assert property (
    cmd_done && cmd_byte == {`SGR_PIN_SEL_VAL, `SGR_PIN_OP_CFG}
    |=> state_q == st_cfg)
    else $error("configure command not selected");

  a_cfg_commit: assert property (
    cs_rise && pend_cfg_q |=> cfg_q == $past(pend_q))
    else $error("configuration not committed at chip select rise");

  a_commit_only: assert property (
    !cs_rise && !rst_full |=> ($stable(cfg_q) && $stable(wr_q)))
    else $error("pin register changed outside chip select rise");

  a_pin_reset: assert property (
    $past(reset) |-> (cfg_q == '0 && wr_q == '1))
    else $error("pins not inputs after reset");

  a_read_load: assert property (
    s_rd_cmd |=> (state_q == st_rd && rd_q == DATA_BITS'($past(pin_i))))
    else $error("read word not loaded");

  a_sdo_quiet: assert property (
    state_q != st_rd |=> !sdo_raw_q)
    else $error("serial output not quiet");

endmodule

// [verification/sgr_host.sv]
// spi host model that drives the serial command link of the pin block
module sgr_host #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic mclk,
  // serial link
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------
  // link idle: clock low, chip select high
  // ------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic begin_frame();
    @(posedge mclk);
    cs_n <= 1'b0;
    wait_n(2);
  endtask

  // one bit: data set, sdo taken, clock high, clock low
  task automatic xbit(input logic b, output logic s);
    sdi <= b;
    wait_n(HALF);
    s = sdo;
    sclk <= 1'b1;
    wait_n(HALF);
    sclk <= 1'b0;
  endtask

  // released data line shows the inverse of its last value
  task automatic end_frame();
    wait_n(HALF);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    wait_n(6);
  endtask
endmodule

// [verification/test_serial_gpio_and_reset_commands.sv]
// self-checking bench for the serial pin and reset command decoder
module test_serial_gpio_and_reset_commands
  import sgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] wr;
    logic [11:0] pins;
    logic [11:0] oe;
    logic [11:0] o;
  } sgr_row_s;

  logic        mclk       = 1'b0;
  logic        reset      = 1'b1;
  logic        sel4       = 1'b0;
  logic [1:0]  clock_mode = 2'h0;
  logic [11:0] pin_i      = 12'h000;
  logic [11:0] prev_wr    = 12'hfff;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo4;
  logic        sdo_or;
  logic [15:0] q;
  sgr_ctl_s    ctl;
  logic [11:0] pin_o;
  logic [11:0] pin_oe;
  logic [3:0]  pin_o4;
  logic [3:0]  pin_oe4;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  int          n_clr      = 0;
  int          n_full     = 0;

  sgr_row_s rows [3] = '{
    '{16'hfff0, 16'ha5c0, 12'h3c5, 12'hfff, 12'ha5c},
    '{16'h0000, 16'h0f30, 12'ha5a, 12'hf0c, 12'h000},
    '{16'hc3a0, 16'h5690, 12'h5c3, 12'hebe, 12'h428}
  };

  always #4 mclk = ~mclk;

  sgr_host host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
                 .sdo(sel4 ? sdo4 : sdo));

  sgr_top dut (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
               .sdi(sdi), .sdo(sdo), .clock_mode(clock_mode), .ctl_q(ctl),
               .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

  sgr_top #(.NUM_PINS(4)) dut4 (.mclk(mclk), .reset(reset), .cs_n(cs_n),
               .sclk(sclk), .sdi(sdi), .sdo(sdo4), .clock_mode(clock_mode),
               .ctl_q(), .pin_i(pin_i[11:8]), .pin_o(pin_o4),
               .pin_oe(pin_oe4));

  // ------------------
  // helpers
  // ------------------
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // command byte then nbits of data, sdo gathered msb first
  task automatic frame(input logic [7:0] c, input logic [15:0] d,
                       input int nbits);
    logic s;
    sdo_or = 1'b0;
    q = 16'h0000;
    host.begin_frame();
    for (int i = 7; i >= 0; i--) begin
      host.xbit(c[i], s);
      sdo_or |= s;
    end
    for (int i = 15; i >= 16 - nbits; i--) begin
      host.xbit(d[i], s);
      q[i] = s;
    end
  endtask

  // control pulses counted per cycle, plus the hang limit
  always @(posedge mclk) begin
    cycles++;
    if (ctl.fifo_clear === 1'b1)
      n_clr++;
    if (ctl.full_reset === 1'b1)
      n_full++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ------------------
  // sequence
  // ------------------
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("oe_reset", 16'h0000, {4'h0, pin_oe});
    chk("o_reset", 16'h0000, {4'h0, pin_o});
    chk("ctl_reset", 16'h0000, {11'h0, ctl});
    foreach (rows[k]) begin
      frame(8'h03, rows[k].cfg, 16);
      chk("sdo_cfg", 16'h0000, q | {15'h0, sdo_or});
      host.end_frame();
      frame(8'h02, rows[k].wr, 16);
      chk("sdo_wr", 16'h0000, q | {15'h0, sdo_or});
      chk("oe_pend", {4'h0, rows[k].cfg[15:4] | ~prev_wr},
          {4'h0, pin_oe});
      host.end_frame();
      prev_wr = rows[k].wr[15:4];
      chk("oe", {4'h0, rows[k].oe}, {4'h0, pin_oe});
      chk("o", {4'h0, rows[k].o}, {4'h0, pin_o});
      chk("oe4", {12'h0, rows[k].oe[11:8]}, {12'h0, pin_oe4});
      chk("o4", {12'h0, rows[k].o[11:8]}, {12'h0, pin_o4});
      pin_i <= rows[k].pins;
      frame(8'h01, 16'h0000, 16);
      host.end_frame();
      chk("read12", {4'h0, rows[k].pins}, q);
      sel4 <= 1'b1;
      frame(8'h01, 16'h0000, 16);
      host.end_frame();
      sel4 <= 1'b0;
      chk("read4", {4'h0, rows[k].pins[11:8], 8'h00}, q);
    end
    frame(8'h0b, 16'h0000, 0);
    host.end_frame();
    chk("lv_set", 16'h0003,
        {14'h0, ctl.slow_out, ctl.force_bias_on});
    chk("clr1", 16'h0001, n_clr[15:0]);
    for (int m = 0; m < 4; m++) begin
      clock_mode <= m[1:0];
      repeat (3) @(posedge mclk);
      chk("wake", {15'h0, m[0]}, {15'h0, ctl.wake_skip});
    end
    frame(8'h01, 16'h0000, 16);
    host.end_frame();
    chk("read_slow", {4'h0, rows[2].pins}, q);
    frame(8'h08, 16'h0000, 0);
    host.end_frame();
    chk("lv_clr", 16'h0000,
        {14'h0, ctl.slow_out, ctl.force_bias_on});
    chk("clr2", 16'h0002, n_clr[15:0]);
    chk("full0", 16'h0000, n_full[15:0]);
    frame(8'h03, 16'h0000, 8);
    host.end_frame();
    chk("oe_short", {4'h0, rows[2].oe}, {4'h0, pin_oe});
    frame(8'h0c, 16'h0000, 0);
    host.end_frame();
    chk("full1", 16'h0001, n_full[15:0]);
    chk("clr3", 16'h0003, n_clr[15:0]);
    chk("oe_full", 16'h0000, {4'h0, pin_oe});
    end_of_test();
  end
endmodule
